//--- src/vpsei_pkg.sv
// vpsei_pkg: codes, offsets, timing and carrier types for the plot/serial interpreter.
// assumes a 50 MHz system clock and a byte-wide command stream.
package vpsei_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;

  // stream codes
  localparam logic [7:0] CODE_PLOT     = 8'h02;
  localparam logic [7:0] CODE_PLOT_ESC = 8'hFF;
  localparam logic [7:0] CODE_SUB_INC  = 8'hF0;
  localparam logic [7:0] CODE_SUB_Y    = 8'hF1;
  localparam logic [7:0] CODE_SUB_X    = 8'hF2;
  localparam logic [7:0] CODE_SUB_MIN  = 8'hF0;
  localparam logic [7:0] CODE_ESC      = 8'h1B;
  localparam logic [7:0] CODE_DUMP     = 8'h18;
  localparam logic [7:0] CODE_LF       = 8'h0A;
  localparam logic [7:0] CODE_CR       = 8'h0D;
  localparam logic [7:0] REP_HEAD      = 8'h03;
  localparam logic [7:0] REP_MID       = 8'h06;
  localparam logic [7:0] REP_TAIL      = 8'h0D;
  localparam logic [2:0] REP_LAST      = 3'h6;
  localparam logic [7:0] DUMP_END_CHAR = 8'hFF;
  localparam logic [7:0] DUMP_END_STAT = 8'h00;

  // escape letters, compared on their low five bits so control forms match too
  localparam logic [4:0] ESC_BAUD  = 5'h12;
  localparam logic [4:0] ESC_REDIR = 5'h0D;
  localparam logic [4:0] ESC_CREP  = 5'h03;
  localparam logic [4:0] ESC_HALF  = 5'h08;
  localparam logic [4:0] ESC_FULL  = 5'h06;
  localparam logic [4:0] ESC_FILL  = 5'h19;
  localparam logic [4:0] ESC_JMP_A = 5'h09;
  localparam logic [4:0] ESC_JMP_B = 5'h13;
  localparam logic [4:0] ESC_JMP_C = 5'h14;
  localparam logic [4:0] ESC_USER  = 5'h1E;

  localparam logic [15:0] JMP_ADDR_A    = 16'h9000;
  localparam logic [15:0] JMP_ADDR_B    = 16'hA000;
  localparam logic [15:0] JMP_ADDR_C    = 16'h8200;
  localparam logic [15:0] JMP_USER_VEC  = 16'h81BF;

  // serial
  localparam logic [2:0] BAUD_RST      = 3'h7;
  localparam logic [3:0] TX_REST_1STOP = 4'h9;
  localparam logic [3:0] TX_REST_2STOP = 4'hA;

  function automatic int baud_of(input int idx);
    case (idx)
      1:       return 110;
      2:       return 150;
      3:       return 300;
      4:       return 1200;
      5:       return 2400;
      6:       return 4800;
      default: return 9600;
    endcase
  endfunction

  // register map
  localparam logic [7:0] REG_ROUTE = 8'h00;
  localparam logic [7:0] REG_CTRL  = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;

  typedef enum logic [1:0] {SUB_NONE, SUB_INC, SUB_Y, SUB_X} vpsei_sub_e;
  typedef enum logic [1:0] {DUP_LOCAL, DUP_HALF, DUP_FULL} vpsei_dup_e;

  typedef struct packed {
    logic [6:0] x;
    logic [6:0] y;
  } vpsei_pt_s;

  typedef struct packed {
    vpsei_pt_s from;
    vpsei_pt_s to;
  } vpsei_vec_s;

endpackage

//--- src/vpsei_interp.sv
// vpsei_interp: byte-stream interpreter for vector plot submodes and serial escapes.
// assumes a source that holds in_valid/in_byte until in_ready, and a refresh memory
// answering mem_rd one cycle later; two bytes per cell, character then status.
module vpsei_interp #(
  parameter int COL_W       = 6,
  parameter int ROW_W       = 5,
  parameter int DIVW        = 20,
  parameter int BAUD_CLK_HZ = vpsei_pkg::CLK_HZ
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  input  wire logic                     in_valid,
  input  wire logic [7:0]               in_byte,
  input  wire logic                     in_from_kbd,
  output logic                          in_ready,
  input  wire logic                     break_key,
  input  wire logic [COL_W-1:0]         cursor_x,
  input  wire logic [ROW_W-1:0]         cursor_y,
  input  wire logic [7:0]               vis_status,
  output logic                          mem_rd,
  output logic [COL_W+ROW_W:0]          mem_addr,
  input  wire logic [7:0]               mem_rdata,
  output logic                          disp_valid,
  output logic [7:0]                    disp_char,
  output logic                          draw_valid,
  output vpsei_pkg::vpsei_vec_s         draw_vec,
  output logic                          fill_valid,
  output logic [7:0]                    fill_char,
  output logic [7:0]                    fill_status,
  output logic                          jump_valid,
  output logic [15:0]                   jump_addr,
  output logic                          ser_tx
);

  localparam int CELL_W = COL_W + ROW_W;

  generate
    if (COL_W < 1 || ROW_W < 1 || CELL_W > 15) begin : g_bad_geom
      $error("screen geometry out of range");
    end
    if ((BAUD_CLK_HZ / 110) >= (2 ** DIVW)) begin : g_bad_div
      $error("baud divider too narrow");
    end
  endgenerate

  typedef enum logic [3:0] {
    S_IDLE, S_ESC, S_BAUD, S_FILL, S_RD_C, S_W_C, S_GET_C, S_W_S, S_GET_S,
    S_REP_TX, S_DMP_TX, S_DMP_LF, S_DMP_CR
  } vpsei_st_e;

  function automatic logic [6:0] step(input logic [6:0] c, input logic [1:0] f);
    case (f)
      2'h1:    return c - 7'h01;
      2'h2:    return c + 7'h01;
      default: return c;
    endcase
  endfunction

  vpsei_st_e              state_q, state_d;
  vpsei_pkg::vpsei_sub_e  sub_q;
  vpsei_pkg::vpsei_dup_e  dup_q;
  vpsei_pkg::vpsei_pt_s   p0_q, p1_q, p0_n, p1_n;
  logic                   plot_q, redirect_q, stop_count_q, two_stop_q, dump_q;
  logic [2:0]             baud_q, rep_idx_q;
  logic [CELL_W-1:0]      cell_q;
  logic [7:0]             cell_char_q, cell_stat_q;
  logic [DIVW-1:0]        div_tab [1:7];
  logic [DIVW-1:0]        tx_cnt_q;
  logic [8:0]             tx_sh_q;
  logic [3:0]             tx_rest_q;
  logic                   tx_busy_q, tx_pend_q, tx_pend_d, tx_take;
  logic [7:0]             tx_data_q, push_byte;
  logic                   push;

  genvar gi;
  generate
    for (gi = 1; gi <= 7; gi++) begin : g_div
      assign div_tab[gi] = DIVW'(BAUD_CLK_HZ / vpsei_pkg::baud_of(gi) - 1);
    end
  endgenerate

  // decoded events
  logic acc, idle_acc, esc_acc, plot_byte, plot_enter, char_ev, to_ser, to_disp;
  logic baud_ok, col_last;
  logic [4:0] letter;
  assign acc        = in_valid && in_ready;
  assign idle_acc   = acc && state_q == S_IDLE;
  assign esc_acc    = acc && state_q == S_ESC;
  assign letter     = in_byte[4:0];
  assign plot_byte  = idle_acc && plot_q;
  assign plot_enter = idle_acc && !plot_q && in_byte == vpsei_pkg::CODE_PLOT;
  assign char_ev    = idle_acc && !plot_q && in_byte != vpsei_pkg::CODE_PLOT
                      && in_byte != vpsei_pkg::CODE_ESC && in_byte != vpsei_pkg::CODE_DUMP;
  assign to_ser     = redirect_q || (in_from_kbd && dup_q != vpsei_pkg::DUP_LOCAL);
  assign to_disp    = !redirect_q && (!in_from_kbd || dup_q != vpsei_pkg::DUP_FULL);
  assign baud_ok    = (in_byte[7:4] == 4'h0 || in_byte[7:4] == 4'h3)
                      && in_byte[3:0] >= 4'h1 && in_byte[3:0] <= 4'h7;
  assign col_last   = &cell_q[COL_W-1:0];

  function automatic logic [7:0] rep_byte(input logic [2:0] i, input logic [7:0] xc,
                                          input logic [7:0] yc, input logic [7:0] st,
                                          input logic [7:0] ch);
    case (i)
      3'h0:    return vpsei_pkg::REP_HEAD;
      3'h1:    return xc;
      3'h2:    return yc;
      3'h3:    return vpsei_pkg::REP_MID;
      3'h4:    return st;
      3'h5:    return ch;
      default: return vpsei_pkg::REP_TAIL;
    endcase
  endfunction

  always_comb begin
    state_d   = state_q;
    push      = 1'b0;
    push_byte = 8'h00;
    case (state_q)
      S_IDLE: begin
        if (idle_acc && !plot_q && in_byte == vpsei_pkg::CODE_ESC) begin
          state_d = S_ESC;
        end else if (idle_acc && !plot_q && in_byte == vpsei_pkg::CODE_DUMP) begin
          state_d = S_RD_C;
        end else if (char_ev && to_ser) begin
          push      = 1'b1;
          push_byte = in_byte;
        end
      end
      S_ESC: begin
        if (esc_acc) begin
          if (letter == vpsei_pkg::ESC_BAUD) begin
            state_d = S_BAUD;
          end else if (letter == vpsei_pkg::ESC_FILL) begin
            state_d = S_FILL;
          end else if (letter == vpsei_pkg::ESC_CREP) begin
            state_d = S_RD_C;
          end else begin
            state_d = S_IDLE;
          end
        end
      end
      S_BAUD, S_FILL: begin
        if (acc) begin
          state_d = S_IDLE;
        end
      end
      S_RD_C:  state_d = S_W_C;
      S_W_C:   state_d = S_GET_C;
      S_GET_C: state_d = S_W_S;
      S_W_S:   state_d = S_GET_S;
      S_GET_S: begin
        if (!dump_q) begin
          state_d = S_REP_TX;
        end else if (cell_char_q == vpsei_pkg::DUMP_END_CHAR
                     && mem_rdata == vpsei_pkg::DUMP_END_STAT) begin
          state_d = S_IDLE;
        end else begin
          state_d = S_DMP_TX;
        end
      end
      S_REP_TX: begin
        if (!tx_pend_q) begin
          push      = 1'b1;
          push_byte = rep_byte(rep_idx_q, 8'(cursor_x), 8'(cursor_y), cell_stat_q, cell_char_q);
          if (rep_idx_q == vpsei_pkg::REP_LAST) begin
            state_d = S_IDLE;
          end
        end
      end
      S_DMP_TX: begin
        if (!tx_pend_q) begin
          push      = 1'b1;
          push_byte = cell_char_q;
          state_d   = col_last ? S_DMP_LF : S_RD_C;
        end
      end
      S_DMP_LF: begin
        if (!tx_pend_q) begin
          push      = 1'b1;
          push_byte = vpsei_pkg::CODE_LF;
          state_d   = S_DMP_CR;
        end
      end
      S_DMP_CR: begin
        if (!tx_pend_q) begin
          push      = 1'b1;
          push_byte = vpsei_pkg::CODE_CR;
          state_d   = (cell_q == '0) ? S_IDLE : S_RD_C;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // source is stalled whenever the serial holding byte is occupied
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (state_d == S_IDLE || state_d == S_ESC || state_d == S_BAUD
                   || state_d == S_FILL) && !tx_pend_d;
    end
  end

  // plot submodes
  always_comb begin
    p0_n = p0_q;
    p1_n = p1_q;
    if (sub_q == vpsei_pkg::SUB_INC) begin
      p0_n.x = step(p0_q.x, in_byte[7:6]);
      p0_n.y = step(p0_q.y, in_byte[5:4]);
      p1_n.x = step(p1_q.x, in_byte[3:2]);
      p1_n.y = step(p1_q.y, in_byte[1:0]);
    end else if (sub_q == vpsei_pkg::SUB_Y) begin
      p0_n.y = in_byte[6:0];
      p1_n   = p0_n;
    end else if (sub_q == vpsei_pkg::SUB_X) begin
      p0_n.x = in_byte[6:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      plot_q     <= 1'b0;
      sub_q      <= vpsei_pkg::SUB_NONE;
      p0_q       <= '0;
      p1_q       <= '0;
      draw_valid <= 1'b0;
      draw_vec   <= '0;
    end else begin
      draw_valid <= 1'b0;
      if (plot_enter) begin
        plot_q <= 1'b1;
      end else if (plot_byte) begin
        if (in_byte == vpsei_pkg::CODE_PLOT_ESC) begin
          plot_q <= 1'b0;
        end else if (in_byte == vpsei_pkg::CODE_SUB_INC) begin
          sub_q <= vpsei_pkg::SUB_INC;
        end else if (in_byte == vpsei_pkg::CODE_SUB_Y) begin
          sub_q <= vpsei_pkg::SUB_Y;
        end else if (in_byte == vpsei_pkg::CODE_SUB_X) begin
          sub_q <= vpsei_pkg::SUB_X;
        end else if (in_byte >= vpsei_pkg::CODE_SUB_MIN) begin
          sub_q <= vpsei_pkg::SUB_NONE;
        end else begin
          p0_q <= p0_n;
          p1_q <= p1_n;
          if (sub_q == vpsei_pkg::SUB_X) begin
            sub_q <= vpsei_pkg::SUB_Y;
          end else if (sub_q == vpsei_pkg::SUB_Y) begin
            sub_q         <= vpsei_pkg::SUB_X;
            draw_valid    <= 1'b1;
            draw_vec.from <= p1_q;
            draw_vec.to   <= p0_n;
          end else if (sub_q == vpsei_pkg::SUB_INC) begin
            // submode is left untouched here
            draw_valid    <= (in_byte[7:4] != 4'h0) && (in_byte[3:0] != 4'h0);
            draw_vec.from <= p1_n;
            draw_vec.to   <= p0_n;
          end
        end
      end
    end
  end

  // terminal modes and serial configuration
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dup_q        <= vpsei_pkg::DUP_LOCAL;
      redirect_q   <= 1'b0;
      stop_count_q <= 1'b0;
      baud_q       <= vpsei_pkg::BAUD_RST;
      two_stop_q   <= 1'b0;
    end else begin
      if (esc_acc && letter == vpsei_pkg::ESC_HALF) begin
        dup_q <= vpsei_pkg::DUP_HALF;
      end else if (esc_acc && letter == vpsei_pkg::ESC_FULL) begin
        dup_q <= vpsei_pkg::DUP_FULL;
      end else if (break_key && dup_q == vpsei_pkg::DUP_FULL) begin
        dup_q <= vpsei_pkg::DUP_HALF;
      end
      // the escape setting the flag beats a same-cycle software clear
      if (esc_acc && letter == vpsei_pkg::ESC_REDIR) begin
        redirect_q <= 1'b1;
      end else if (reg_wr && reg_addr == vpsei_pkg::REG_ROUTE) begin
        redirect_q <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == vpsei_pkg::REG_CTRL) begin
        stop_count_q <= reg_wdata[0];
      end
      if (acc && state_q == S_BAUD && baud_ok) begin
        baud_q     <= in_byte[2:0];
        two_stop_q <= !stop_count_q;
      end
    end
  end

  // display, fill and jump strobes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      disp_valid  <= 1'b0;
      disp_char   <= 8'h00;
      fill_valid  <= 1'b0;
      fill_char   <= 8'h00;
      fill_status <= 8'h00;
      jump_valid  <= 1'b0;
      jump_addr   <= 16'h0000;
    end else begin
      disp_valid <= char_ev && to_disp;
      // the display data only moves when the display is actually handed the character
      if (char_ev && to_disp) begin
        disp_char <= in_byte;
      end
      fill_valid <= acc && state_q == S_FILL;
      if (acc && state_q == S_FILL) begin
        fill_char   <= in_byte;
        fill_status <= vis_status;
      end
      jump_valid <= 1'b0;
      if (esc_acc) begin
        jump_valid <= 1'b1;
        if (letter == vpsei_pkg::ESC_JMP_A) begin
          jump_addr <= vpsei_pkg::JMP_ADDR_A;
        end else if (letter == vpsei_pkg::ESC_JMP_B) begin
          jump_addr <= vpsei_pkg::JMP_ADDR_B;
        end else if (letter == vpsei_pkg::ESC_JMP_C) begin
          jump_addr <= vpsei_pkg::JMP_ADDR_C;
        end else if (letter == vpsei_pkg::ESC_USER) begin
          jump_addr <= vpsei_pkg::JMP_USER_VEC;
        end else begin
          jump_valid <= 1'b0;
        end
      end
    end
  end

  // refresh memory walk for cursor report and text dump
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dump_q      <= 1'b0;
      cell_q      <= '0;
      rep_idx_q   <= 3'h0;
      cell_char_q <= 8'h00;
      cell_stat_q <= 8'h00;
      mem_rd      <= 1'b0;
      mem_addr    <= '0;
    end else begin
      if (state_q != S_RD_C && state_d == S_RD_C && state_q != S_DMP_TX
          && state_q != S_DMP_CR) begin
        dump_q    <= (state_q == S_IDLE);
        cell_q    <= {cursor_y, cursor_x};
        rep_idx_q <= 3'h0;
      end
      if (state_q == S_GET_C) begin
        cell_char_q <= mem_rdata;
      end
      if (state_q == S_GET_S) begin
        cell_stat_q <= mem_rdata;
      end
      if (state_q == S_REP_TX && push) begin
        rep_idx_q <= rep_idx_q + 3'h1;
      end
      if (state_q == S_DMP_TX && push) begin
        cell_q <= cell_q + 1'b1;
      end
      mem_rd   <= (state_d == S_W_C) || (state_d == S_W_S);
      mem_addr <= {cell_q, state_d == S_W_S};
    end
  end

  // serial framer: one holding byte, eight data bits, no parity
  assign tx_take   = tx_pend_q && !tx_busy_q;
  assign tx_pend_d = push || (tx_pend_q && !tx_take);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_pend_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_busy_q <= 1'b0;
      tx_sh_q   <= '1;
      tx_rest_q <= 4'h0;
      tx_cnt_q  <= '0;
      ser_tx    <= 1'b1;
    end else begin
      tx_pend_q <= tx_pend_d;
      if (push) begin
        tx_data_q <= push_byte;
      end
      if (tx_take) begin
        tx_busy_q <= 1'b1;
        ser_tx    <= 1'b0;
        tx_sh_q   <= {1'b1, tx_data_q};
        tx_rest_q <= two_stop_q ? vpsei_pkg::TX_REST_2STOP : vpsei_pkg::TX_REST_1STOP;
        tx_cnt_q  <= div_tab[baud_q];
      end else if (tx_busy_q) begin
        if (tx_cnt_q != '0) begin
          tx_cnt_q <= tx_cnt_q - 1'b1;
        end else if (tx_rest_q == 4'h0) begin
          tx_busy_q <= 1'b0;
        end else begin
          ser_tx    <= tx_sh_q[0];
          tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
          tx_rest_q <= tx_rest_q - 4'h1;
          tx_cnt_q  <= div_tab[baud_q];
        end
      end
    end
  end

  // register reads
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd && reg_addr == vpsei_pkg::REG_ROUTE) begin
        reg_rdata <= 32'(redirect_q);
      end else if (reg_rd && reg_addr == vpsei_pkg::REG_CTRL) begin
        reg_rdata <= 32'(stop_count_q);
      end else if (reg_rd && reg_addr == vpsei_pkg::REG_STAT) begin
        reg_rdata <= 32'({sub_q, plot_q, dup_q, two_stop_q, baud_q, tx_busy_q});
      end
    end
  end

  property p_y_draw;
    @(posedge clock) disable iff (rst)
    (plot_byte && sub_q == vpsei_pkg::SUB_Y && in_byte < vpsei_pkg::CODE_SUB_MIN)
    |=> draw_valid && draw_vec.to.y == $past(in_byte[6:0]) && p1_q == draw_vec.to
        && sub_q == vpsei_pkg::SUB_X;
  endproperty
  a_y_draw: assert property (p_y_draw) else $error("Y byte did not draw and chain");

  property p_x_to_y;
    @(posedge clock) disable iff (rst)
    (plot_byte && sub_q == vpsei_pkg::SUB_X && in_byte < vpsei_pkg::CODE_SUB_MIN)
    |=> sub_q == vpsei_pkg::SUB_Y && !draw_valid;
  endproperty
  a_x_to_y: assert property (p_x_to_y) else $error("X byte did not advance to Y");

  property p_inc_half_zero;
    @(posedge clock) disable iff (rst)
    (plot_byte && sub_q == vpsei_pkg::SUB_INC && in_byte < vpsei_pkg::CODE_SUB_MIN
     && (in_byte[7:4] == 4'h0 || in_byte[3:0] == 4'h0))
    |=> !draw_valid && sub_q == vpsei_pkg::SUB_INC;
  endproperty
  a_inc_half_zero: assert property (p_inc_half_zero) else $error("drew on zero half");

  property p_baud_set;
    @(posedge clock) disable iff (rst)
    (acc && state_q == S_BAUD && baud_ok)
    |=> baud_q == $past(in_byte[2:0]) && two_stop_q == !$past(stop_count_q);
  endproperty
  a_baud_set: assert property (p_baud_set) else $error("baud or stop count not taken");

  property p_full_duplex;
    @(posedge clock) disable iff (rst)
    (char_ev && in_from_kbd && dup_q == vpsei_pkg::DUP_FULL)
    |=> !disp_valid ##0 !in_ready;
  endproperty
  a_full_duplex: assert property (p_full_duplex) else $error("full duplex key shown");

  property p_break;
    @(posedge clock) disable iff (rst)
    (break_key && dup_q == vpsei_pkg::DUP_FULL && !esc_acc) |=> dup_q == vpsei_pkg::DUP_HALF;
  endproperty
  a_break: assert property (p_break) else $error("break did not leave full duplex");

  property p_redirect;
    @(posedge clock) disable iff (rst)
    (char_ev && redirect_q) |=> !disp_valid && tx_pend_q && tx_data_q == $past(in_byte);
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirected char reached display");

  property p_fill;
    @(posedge clock) disable iff (rst)
    (acc && state_q == S_FILL) |=> fill_valid && fill_status == $past(vis_status);
  endproperty
  a_fill: assert property (p_fill) else $error("fill missing visible status");

  property p_start_bit;
    @(posedge clock) disable iff (rst)
    tx_take |=> !ser_tx [*2];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");

endmodule

//--- tb/vpsei_ser_rx.sv
// vpsei_ser_rx: serial receiver standing in for the printer, modem or host.
// assumes 8 data bits, no parity, BIT clock cycles per bit, line idle high.
module vpsei_ser_rx #(
  parameter int BIT = 100
) (
  input  wire logic       clock,
  input  wire logic       ser_tx,
  output logic      [7:0] rx_byte,
  output int              rx_cnt,
  output int              rx_err
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_cnt = 0;
    rx_err = 0;
    rx_byte = 8'h00;
    forever begin
      @(negedge ser_tx);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock);
        rx_byte[i] = ser_tx;
      end
      repeat (BIT) @(posedge clock);
      if (ser_tx !== 1'b1) rx_err++;
      rx_cnt++;
    end
  end
endmodule

//--- tb/vpsei_interp_tb.sv
// vpsei_interp_tb: directed bench driving bytes and registers of the interpreter.
// assumes a toy refresh memory echoing its address and a serial receiver model.
module vpsei_interp_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 100;
  logic                  clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic                  in_valid = 1'b0, in_from_kbd = 1'b0, break_key = 1'b0;
  logic [7:0]            reg_addr = 8'h00, in_byte = 8'h00, mem_rdata = 8'h00;
  logic [31:0]           reg_wdata = 32'h0, reg_rdata;
  logic [5:0]            cursor_x = 6'h05;
  logic [4:0]            cursor_y = 5'h02;
  logic [7:0]            vis_status = 8'h47, disp_char, fill_char, fill_status, rx_byte;
  logic                  in_ready, mem_rd, disp_valid, draw_valid, fill_valid, jump_valid;
  logic                  ser_tx;
  logic [11:0]           mem_addr;
  logic [15:0]           jump_addr;
  vpsei_pkg::vpsei_vec_s draw_vec;
  logic [7:0]            jl[4] = '{8'h49, 8'h53, 8'h54, 8'h5E};
  logic [15:0]           ja[4] = '{16'h9000, 16'hA000, 16'h8200, 16'h81BF};
  // report bytes for cell (5,2) of the echoing memory, then a dump of the last two cells
  logic [7:0]            ex[11] = '{8'h03, 8'h05, 8'h02, 8'h06, 8'h0B, 8'h0A, 8'h0D,
                                    8'hFC, 8'hFE, 8'h0A, 8'h0D};
  int                    mismatches = 0, samples_checked = 0, n_draw = 0, cycles = 0;
  int                    n_disp = 0, n_fill = 0, n_jump = 0;
  int                    rx_cnt, rx_err;
  vpsei_interp #(.BAUD_CLK_HZ(960000)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_byte(in_byte), .in_from_kbd(in_from_kbd), .in_ready(in_ready),
    .break_key(break_key), .cursor_x(cursor_x), .cursor_y(cursor_y), .vis_status(vis_status),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .disp_valid(disp_valid),
    .disp_char(disp_char), .draw_valid(draw_valid), .draw_vec(draw_vec),
    .fill_valid(fill_valid), .fill_char(fill_char), .fill_status(fill_status),
    .jump_valid(jump_valid), .jump_addr(jump_addr), .ser_tx(ser_tx));
  vpsei_ser_rx #(.BIT(BIT)) far (.clock(clock), .ser_tx(ser_tx), .rx_byte(rx_byte),
    .rx_cnt(rx_cnt), .rx_err(rx_err));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    mem_rdata <= mem_addr[7:0];
    if (draw_valid === 1'b1) n_draw <= n_draw + 1;
    if (disp_valid === 1'b1) n_disp <= n_disp + 1;
    if (fill_valid === 1'b1) n_fill <= n_fill + 1;
    if (jump_valid === 1'b1) n_jump <= n_jump + 1;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk("reg_rdata", e, reg_rdata);
  endtask
  // a hang here is caught by the cycle ceiling
  task automatic send(input logic [7:0] b, input logic k);
    @(posedge clock);
    in_valid <= 1'b1;
    in_byte <= b;
    in_from_kbd <= k;
    do begin
      @(posedge clock);
    end while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // ends past a second stop bit but before a queued next frame's first data bit is sampled
  task automatic rxwait(input int c);
    while (rx_cnt < c) @(posedge clock);
    repeat (BIT + 75) @(posedge clock);
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(vpsei_pkg::REG_STAT, 32'h0E);
    rd(8'h0C, 32'h0);
    send(8'h41, 1'b1);
    chk("disp_char", 8'h41, disp_char);
    wr(vpsei_pkg::REG_CTRL, 32'h0);
    send(8'h1B, 1'b0);
    send(8'h52, 1'b0);
    send(8'h37, 1'b0);
    send(8'h1B, 1'b0);
    send(8'h48, 1'b0);
    rd(vpsei_pkg::REG_STAT, 32'h3E);
    send(8'h55, 1'b1);
    rxwait(1);
    chk("rx_byte", 8'h55, rx_byte);
    chk("disp_char", 8'h55, disp_char);
    send(8'h1B, 1'b0);
    send(8'h46, 1'b0);
    send(8'h3C, 1'b1);
    rxwait(2);
    chk("rx_byte", 8'h3C, rx_byte);
    chk("disp_char", 8'h55, disp_char);
    @(posedge clock) break_key <= 1'b1;
    @(posedge clock) break_key <= 1'b0;
    rd(vpsei_pkg::REG_STAT, 32'h3E);
    send(8'h02, 1'b0);
    send(8'hF2, 1'b0);
    send(8'h0A, 1'b0);
    send(8'h14, 1'b0);
    chk("draw_vec", {4'h0, 7'h00, 7'h00, 7'h0A, 7'h14}, draw_vec);
    send(8'h1E, 1'b0);
    send(8'h28, 1'b0);
    chk("draw_vec", {4'h0, 7'h0A, 7'h14, 7'h1E, 7'h28}, draw_vec);
    send(8'hF1, 1'b0);
    send(8'h05, 1'b0);
    chk("draw_vec", {4'h0, 7'h1E, 7'h28, 7'h1E, 7'h05}, draw_vec);
    send(8'hF0, 1'b0);
    send(8'h9A, 1'b0);
    chk("draw_vec", {4'h0, 7'h1F, 7'h06, 7'h1F, 7'h04}, draw_vec);
    send(8'h90, 1'b0);
    send(8'h65, 1'b0);
    chk("draw_vec", {4'h0, 7'h1E, 7'h05, 7'h1F, 7'h04}, draw_vec);
    chk("n_draw", 32'h5, n_draw);
    send(8'hFF, 1'b0);
    foreach (jl[i]) begin
      send(8'h1B, 1'b0);
      send(jl[i], 1'b0);
      chk("jump_addr", ja[i], jump_addr);
    end
    chk("n_jump", 32'h4, n_jump);
    send(8'h1B, 1'b0);
    send(8'h59, 1'b0);
    send(8'h5A, 1'b0);
    chk("fill_char", 8'h5A, fill_char);
    chk("fill_status", 8'h47, fill_status);
    chk("n_fill", 32'h1, n_fill);
    wr(vpsei_pkg::REG_CTRL, 32'h1);
    send(8'h1B, 1'b0);
    send(8'h52, 1'b0);
    send(8'h06, 1'b0);
    rd(vpsei_pkg::REG_STAT, 32'h12C);
    send(8'h1B, 1'b0);
    send(8'h52, 1'b0);
    send(8'h37, 1'b0);
    send(8'h1B, 1'b0);
    send(8'h43, 1'b0);
    for (int i = 0; i < 7; i++) begin
      rxwait(3 + i);
      chk("rx_byte", ex[i], rx_byte);
    end
    cursor_x <= 6'h3E;
    cursor_y <= 5'h1F;
    send(8'h18, 1'b0);
    for (int i = 7; i < 11; i++) begin
      rxwait(3 + i);
      chk("rx_byte", ex[i], rx_byte);
    end
    send(8'h1B, 1'b0);
    send(8'h4D, 1'b0);
    rd(vpsei_pkg::REG_ROUTE, 32'h1);
    send(8'h61, 1'b0);
    rxwait(14);
    chk("rx_byte", 8'h61, rx_byte);
    chk("disp_char", 8'h55, disp_char);
    wr(vpsei_pkg::REG_ROUTE, 32'h0);
    send(8'h62, 1'b0);
    chk("disp_char", 8'h62, disp_char);
    chk("n_disp", 32'h3, n_disp);
    chk("rx_err", 32'h0, rx_err);
    conclude();
  end
endmodule
